/* File: testbench/reset_source_flags_bench.sv */
/*
 * reset_source_flags_bench: self-checking bench for rsf_reset_flags,
 * register access over AHB-Lite plus pulsed reset events.
 * assumes: one 100 MHz clock, hready looped back from hreadyout,
 * design parameters left at their defaults.
 */
module reset_source_flags_bench
    import rsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 4000;

    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [1:0] hresp;
    logic low_supply_level;
    logic wdog_timeout;
    logic sleep_mode;
    logic wdog_ctrl_sw_reset;
    logic halt_enter;
    logic sys_reset;
    logic pc_sp_clear;
    logic [2:0] stack_ptr;
    logic [7:0] port_data;
    logic [7:0] port_dir;
    logic int_enable;
    logic timer_enable;
    logic wdog_clear;
    logic wdog_run;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int n_sys = 0;
    int n_pc = 0;
    int n_wc = 0;

    rsf_reset_flags dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .low_supply_level(low_supply_level), .wdog_timeout(wdog_timeout),
        .sleep_mode(sleep_mode), .wdog_ctrl_sw_reset(wdog_ctrl_sw_reset),
        .halt_enter(halt_enter), .sys_reset(sys_reset), .pc_sp_clear(pc_sp_clear),
        .stack_ptr(stack_ptr), .port_data(port_data), .port_dir(port_dir),
        .int_enable(int_enable), .timer_enable(timer_enable),
        .wdog_clear(wdog_clear), .wdog_run(wdog_run)
    );

    // ****************************************************************
    // clock, pulse counters and hang limit
    // ****************************************************************
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (hresetn === 1'b1) begin
            n_sys = n_sys + int'(sys_reset === 1'b1);
            n_pc = n_pc + int'(pc_sp_clear === 1'b1);
            n_wc = n_wc + int'(wdog_clear === 1'b1);
        end
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            num_errors = num_errors + 1;
            finish_test();
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", 32'h0, {30'h0, hresp});
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [31:0] x;
        bus(a, 1'b0, 8'h00, x);
        check(what, {24'h000000, exp}, x);
    endtask : rd

    task automatic fire(input logic [2:0] ev);
        {halt_enter, wdog_ctrl_sw_reset, wdog_timeout} <= ev;
        @(posedge hclk);
        {halt_enter, wdog_ctrl_sw_reset, wdog_timeout} <= 3'h0;
        repeat (4) @(posedge hclk);
    endtask : fire

    task automatic counts(input int s, input int p, input int w);
        check("sys_reset count", s, n_sys);
        check("pc_sp_clear count", p, n_pc);
        check("wdog_clear count", w, n_wc);
    endtask : counts

    task automatic por();
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        check("wdog_clear in reset", 32'h1, {31'h0, wdog_clear});
        check("wdog_run in reset", 32'h0, {31'h0, wdog_run});
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        check("wdog_run", 32'h1, {31'h0, wdog_run});
        check("stack_ptr", 32'h7, {29'h0, stack_ptr});
        check("ints timers", 32'h0, {30'h0, int_enable, timer_enable});
        check("ports", 32'hffff, {16'h0, port_data, port_dir});
        n_sys = 0;
        n_pc = 0;
        n_wc = 0;
    endtask : por

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        low_supply_level = 1'b0;
        wdog_timeout = 1'b0;
        sleep_mode = 1'b0;
        wdog_ctrl_sw_reset = 1'b0;
        halt_enter = 1'b0;
        por();
        rd(ADDR_FLAGS, 8'h00, "flags");
        rd(ADDR_STATUS, 8'h00, "status");
        rd(ADDR_CORE, 8'h00, "core");
        $display("test power_on done");

        wr(8'h10, 8'ha5);
        wr(8'h14, 8'h3c);
        wr(ADDR_PDATA, 8'h12);
        wr(ADDR_PDIR, 8'h34);
        wr(ADDR_CORE, 8'h03);
        wr(ADDR_FLAGS, 8'hff);
        rd(ADDR_FLAGS, 8'h00, "flags unused bits");
        rd(8'h20, 8'h00, "unmapped");
        rd(8'h10, 8'ha5, "accumulator");
        rd(ADDR_PDIR, 8'h34, "port_dir reg");
        $display("test registers done");

        fire(3'h4);
        rd(ADDR_STATUS, 8'h10, "status after halt");
        fire(3'h1);
        counts(1, 1, 1);
        rd(ADDR_STATUS, 8'h30, "status normal timeout");
        rd(8'h10, 8'ha5, "accumulator kept");
        rd(8'h14, 8'h3c, "table_pointer kept");
        rd(ADDR_CORE, 8'h00, "core after timeout");
        check("ports", 32'hffff, {16'h0, port_data, port_dir});
        check("stack_ptr", 32'h7, {29'h0, stack_ptr});
        rd(ADDR_FLAGS, 8'h00, "flags kept");
        $display("test normal timeout done");

        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, 8'h00, "status cleared");
        wr(ADDR_PDATA, 8'h5a);
        wr(ADDR_CORE, 8'h01);
        sleep_mode <= 1'b1;
        fire(3'h1);
        counts(1, 2, 1);
        check("stack_ptr sleep", 32'h0, {29'h0, stack_ptr});
        rd(ADDR_STATUS, 8'h30, "status sleep timeout");
        check("port_data kept", 32'h5a, {24'h0, port_data});
        rd(ADDR_CORE, 8'h01, "core kept");
        rd(8'h14, 8'h3c, "table_pointer kept");
        sleep_mode <= 1'b0;
        $display("test sleep timeout done");

        fire(3'h2);
        counts(2, 3, 2);
        rd(ADDR_FLAGS, 8'h01, "ctrl reset flag");
        rd(ADDR_STATUS, 8'h30, "status kept");
        wr(ADDR_FLAGS, 8'h01);
        rd(ADDR_FLAGS, 8'h01, "flag write one");
        wr(ADDR_FLAGS, 8'h00);
        rd(ADDR_FLAGS, 8'h00, "flag write zero");
        $display("test ctrl reset done");

        wr(ADDR_FCTL2, 8'h12);
        rd(ADDR_FCTL2, 8'h12, "flash ctrl");
        counts(2, 3, 2);
        wr(ADDR_FCTL2, 8'h55);
        repeat (3) @(posedge hclk);
        counts(3, 4, 3);
        rd(ADDR_FCTL2, 8'h00, "flash ctrl after key");
        rd(8'h10, 8'ha5, "accumulator kept");
        $display("test key write done");

        low_supply_level <= 1'b1;
        repeat (6) @(posedge hclk);
        low_supply_level <= 1'b0;
        repeat (8) @(posedge hclk);
        counts(4, 5, 4);
        rd(ADDR_FLAGS, 8'h04, "low supply flag");
        rd(ADDR_STATUS, 8'h30, "status low supply");
        fire(3'h1);
        rd(ADDR_FLAGS, 8'h04, "flag over timeout");
        wr(ADDR_FLAGS, 8'hfb);
        rd(ADDR_FLAGS, 8'h00, "low supply cleared");
        sleep_mode <= 1'b1;
        low_supply_level <= 1'b1;
        repeat (6) @(posedge hclk);
        low_supply_level <= 1'b0;
        repeat (8) @(posedge hclk);
        rd(ADDR_FLAGS, 8'h00, "low supply in sleep");
        sleep_mode <= 1'b0;
        $display("test low supply done");

        wr(ADDR_CORE, 8'h03);
        wr(ADDR_PDIR, 8'h00);
        rd(ADDR_CORE, 8'h03, "core before power-on");
        por();
        rd(ADDR_STATUS, 8'h00, "status after power-on");
        rd(ADDR_FLAGS, 8'h00, "flags after power-on");
        rd(8'h10, 8'h00, "accumulator power-on");
        $display("test second power_on done");
        finish_test();
    end
endmodule : reset_source_flags_bench

/* File: verilog/rsf_lvl_sync.sv */
/*
 * rsf_lvl_sync: three-stage synchroniser for an asynchronous level;
 * the settled level changes once stages two and three agree.
 * assumes: raw level may change at any time relative to clk.
 */
module rsf_lvl_sync (
    input wire logic clk,
    input wire logic rstn,
    rsf_sync_if.src sif
);

    logic s1;
    logic s2;
    logic s3;

    // ****************************************************************
    // synchroniser chain
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= sif.raw_level;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // ****************************************************************
    // settled level and rise pulse
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sif.stable <= 1'b0;
            sif.rise <= 1'b0;
        end else begin
            if (s2 == s3) begin
                sif.stable <= s3;
            end
            sif.rise <= (s2 == s3) && s3 && !sif.stable;
        end
    end

endmodule : rsf_lvl_sync

/* File: verilog/rsf_pkg.sv */
/*
 * rsf_pkg: register map, field positions and reset values of the
 * reset source and reset flag block.
 * assumes: one 32-bit AHB-Lite slave port, each register one aligned word,
 * 8-bit register data in the low byte.
 */
package rsf_pkg;

    // ****************************************************************
    // register byte addresses (low address byte)
    // ****************************************************************
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_FCTL2 = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CORE = 8'h0c;
    localparam logic [7:0] ADDR_ACC = 8'h10;
    localparam logic [7:0] ADDR_TABLE_POINTER = 8'h14;
    localparam logic [7:0] ADDR_PDATA = 8'h18;
    localparam logic [7:0] ADDR_PDIR = 8'h1c;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BIT_WCR = 0;
    localparam int BIT_LSR = 2;
    localparam int BIT_PDF = 4;
    localparam int BIT_TO = 5;
    localparam int BIT_INT_EN = 0;
    localparam int BIT_TMR_EN = 1;
    localparam int BIT_TRANS_ACT = 1;

    // ****************************************************************
    // values
    // ****************************************************************
    localparam logic [7:0] IAP_KEY = 8'h55;
    localparam logic [7:0] PORT_INIT = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [23:0] RD_PAD = 24'h000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;

endpackage : rsf_pkg

/* File: verilog/rsf_reset_flags.sv */
/*
 * rsf_reset_flags: reset source flags, core status flags and the effect
 * of each reset type on core items, reached over an AHB-Lite slave.
 * assumes: hresetn is the power-on reset; watchdog timeout, control
 * software reset and halt come as one-cycle pulses on hclk; the low
 * supply detector level is asynchronous.
 */
module rsf_reset_flags
    import rsf_pkg::*;
#(
    parameter int SP_W = 3,
    parameter logic [SP_W-1:0] STACK_TOP = '1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    input wire logic low_supply_level,
    input wire logic wdog_timeout,
    input wire logic sleep_mode,
    input wire logic wdog_ctrl_sw_reset,
    input wire logic halt_enter,
    output logic sys_reset,
    output logic pc_sp_clear,
    output logic [SP_W-1:0] stack_ptr,
    output logic [7:0] port_data,
    output logic [7:0] port_dir,
    output logic int_enable,
    output logic timer_enable,
    output logic wdog_clear,
    output logic wdog_run
);

    // ****************************************************************
    // bus phase tracking
    // ****************************************************************
    logic dp_wr;
    logic rd_pend;
    logic [7:0] dp_addr;
    logic hit;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;

    logic low_supply_reset_flag;
    logic wdog_ctrl_reset_flag;
    logic timeout_flag;
    logic power_down_flag;
    logic [7:0] flash_ctrl_second;
    logic [7:0] accumulator;
    logic [7:0] table_pointer;

    logic lvr_ev;
    logic iap_ev;
    logic wdt_norm;
    logic sleep_wdt;
    logic full_ev;
    logic any_rst;

    rsf_sync_if lvr_if ();

    assign lvr_if.raw_level = low_supply_level;

    rsf_lvl_sync u_lvr_sync (
        .clk(hclk),
        .rstn(hresetn),
        .sif(lvr_if)
    );

    assign hit = hsel && hready && htrans[BIT_TRANS_ACT];
    assign wbyte = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            rd_pend <= 1'b0;
            dp_addr <= BYTE_ZERO;
        end else begin
            dp_wr <= hit && hwrite;
            rd_pend <= hit && !hwrite;
            if (hit) begin
                dp_addr <= haddr[7:0];
            end
        end
    end

    // ****************************************************************
    // reset event classification
    // ****************************************************************
    // low supply detection is off in sleep mode
    assign lvr_ev = lvr_if.rise && !sleep_mode;
    assign iap_ev = dp_wr && (dp_addr == ADDR_FCTL2) && (wbyte == IAP_KEY);
    assign wdt_norm = wdog_timeout && !sleep_mode;
    assign full_ev = lvr_ev || iap_ev || wdog_ctrl_sw_reset || wdt_norm;
    assign sleep_wdt = wdog_timeout && sleep_mode && !full_ev;
    assign any_rst = full_ev || sleep_wdt;

    // ****************************************************************
    // reset outputs to the core
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_reset <= 1'b0;
            pc_sp_clear <= 1'b0;
        end else begin
            sys_reset <= full_ev;
            pc_sp_clear <= any_rst;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stack_ptr <= STACK_TOP;
        end else if (full_ev) begin
            stack_ptr <= STACK_TOP;
        end else if (sleep_wdt) begin
            stack_ptr <= '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdog_clear <= 1'b1;
            wdog_run <= 1'b0;
        end else begin
            wdog_clear <= full_ev;
            wdog_run <= !full_ev;
        end
    end

    // ****************************************************************
    // reset cause flags
    // ****************************************************************
    // kept over timeouts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_supply_reset_flag <= 1'b0;
            wdog_ctrl_reset_flag <= 1'b0;
        end else begin
            if (dp_wr && dp_addr == ADDR_FLAGS && !wbyte[BIT_LSR]) begin
                low_supply_reset_flag <= 1'b0;
            end
            if (lvr_ev) begin
                low_supply_reset_flag <= 1'b1;
            end
            if (dp_wr && dp_addr == ADDR_FLAGS && !wbyte[BIT_WCR]) begin
                wdog_ctrl_reset_flag <= 1'b0;
            end
            if (wdog_ctrl_sw_reset) begin
                wdog_ctrl_reset_flag <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    // power-on clears both
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timeout_flag <= 1'b0;
            power_down_flag <= 1'b0;
        end else begin
            if (dp_wr && dp_addr == ADDR_STATUS && !wbyte[BIT_TO]) begin
                timeout_flag <= 1'b0;
            end
            if (wdog_timeout) begin
                timeout_flag <= 1'b1;
            end
            if (dp_wr && dp_addr == ADDR_STATUS && !wbyte[BIT_PDF]) begin
                power_down_flag <= 1'b0;
            end
            if (halt_enter || sleep_wdt) begin
                power_down_flag <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // software registers
    // ****************************************************************
    // interrupts and timers off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_enable <= 1'b0;
            timer_enable <= 1'b0;
            flash_ctrl_second <= BYTE_ZERO;
        end else if (full_ev) begin
            int_enable <= 1'b0;
            timer_enable <= 1'b0;
            flash_ctrl_second <= BYTE_ZERO;
        end else if (dp_wr && !sleep_wdt) begin
            if (dp_addr == ADDR_CORE) begin
                int_enable <= wbyte[BIT_INT_EN];
                timer_enable <= wbyte[BIT_TMR_EN];
            end
            if (dp_addr == ADDR_FCTL2) begin
                flash_ctrl_second <= wbyte;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_data <= PORT_INIT;
            port_dir <= PORT_INIT;
        end else if (full_ev) begin
            port_data <= PORT_INIT;
            port_dir <= PORT_INIT;
        end else if (dp_wr && !sleep_wdt) begin
            if (dp_addr == ADDR_PDATA) begin
                port_data <= wbyte;
            end
            if (dp_addr == ADDR_PDIR) begin
                port_dir <= wbyte;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            accumulator <= BYTE_ZERO;
            table_pointer <= BYTE_ZERO;
        end else if (dp_wr && !any_rst) begin
            if (dp_addr == ADDR_ACC) begin
                accumulator <= wbyte;
            end
            if (dp_addr == ADDR_TABLE_POINTER) begin
                table_pointer <= wbyte;
            end
        end
    end

    // ****************************************************************
    // read path, one wait state on reads
    // ****************************************************************
    always_comb begin
        rd_byte = BYTE_ZERO;
        case (dp_addr)
            ADDR_FLAGS: begin
                rd_byte[BIT_LSR] = low_supply_reset_flag;
                rd_byte[BIT_WCR] = wdog_ctrl_reset_flag;
            end
            ADDR_FCTL2: rd_byte = flash_ctrl_second;
            ADDR_STATUS: begin
                rd_byte[BIT_TO] = timeout_flag;
                rd_byte[BIT_PDF] = power_down_flag;
            end
            ADDR_CORE: begin
                rd_byte[BIT_INT_EN] = int_enable;
                rd_byte[BIT_TMR_EN] = timer_enable;
            end
            ADDR_ACC: rd_byte = accumulator;
            ADDR_TABLE_POINTER: rd_byte = table_pointer;
            ADDR_PDATA: rd_byte = port_data;
            ADDR_PDIR: rd_byte = port_dir;
            default: rd_byte = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= {RD_PAD, BYTE_ZERO};
            hreadyout <= 1'b1;
            hresp <= RESP_OKAY;
        end else begin
            hreadyout <= !(hit && !hwrite);
            hresp <= RESP_OKAY;
            if (rd_pend) begin
                hrdata <= {RD_PAD, rd_byte};
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    iap_key_reset_a: assert property (
        dp_wr && dp_addr == ADDR_FCTL2 && wbyte == IAP_KEY |=> sys_reset && wdog_clear)
        else $error("key write did not reset device");
    lsr_flag_set_a: assert property (
        lvr_if.rise && !sleep_mode |=> sys_reset && low_supply_reset_flag)
        else $error("low supply reset flag not set");
    flags_rsvd_zero_a: assert property (
        hit && !hwrite && haddr[7:0] == ADDR_FLAGS ##1 1'b1 |=>
        hreadyout && hrdata[7:3] == 5'h00 && !hrdata[1])
        else $error("unused flag bits not zero");
    wdt_normal_a: assert property (
        wdog_timeout && !sleep_mode |=> sys_reset && timeout_flag
        && port_dir == PORT_INIT && port_data == PORT_INIT && !int_enable)
        else $error("normal timeout not a full reset");
    wdt_pdf_keep_a: assert property (
        wdog_timeout && !sleep_mode && !halt_enter && !dp_wr |=>
        power_down_flag == $past(power_down_flag))
        else $error("normal timeout changed power-down flag");
    wdt_sleep_a: assert property (
        sleep_wdt |=> !sys_reset && pc_sp_clear && stack_ptr == '0
        && timeout_flag && power_down_flag && port_dir == $past(port_dir))
        else $error("sleep timeout effect wrong");
    lvr_keep_status_a: assert property (
        lvr_ev && !wdog_timeout && !halt_enter && !dp_wr |=>
        timeout_flag == $past(timeout_flag) && power_down_flag == $past(power_down_flag))
        else $error("low supply reset changed status flags");
    wcr_flag_set_a: assert property (
        wdog_ctrl_sw_reset |=> wdog_ctrl_reset_flag ##1 wdog_ctrl_reset_flag || $past(dp_wr))
        else $error("control reset flag not set");
    wdog_start_a: assert property (
        wdog_clear && !full_ev |=> wdog_run && !wdog_clear)
        else $error("watchdog did not start after clear");
    full_core_init_a: assert property (
        sys_reset |-> stack_ptr == STACK_TOP && !timer_enable && pc_sp_clear)
        else $error("full reset core state wrong");
    acc_keep_a: assert property (
        any_rst |=> accumulator == $past(accumulator) && table_pointer == $past(table_pointer))
        else $error("reset changed accumulator or table pointer");

    iap_reset_c: cover property (iap_ev ##1 sys_reset);
    sleep_wdt_c: cover property (sleep_wdt ##1 pc_sp_clear);
    lvr_reset_c: cover property (lvr_ev ##1 low_supply_reset_flag);
    flag_read_c: cover property (rd_pend && dp_addr == ADDR_FLAGS);

endmodule : rsf_reset_flags

/* File: verilog/rsf_sync_if.sv */
/*
 * rsf_sync_if: carries a raw pin level into the synchroniser and the
 * settled level and its rising-edge pulse back out.
 * assumes: both ends run on the same clock.
 */
interface rsf_sync_if;
    logic raw_level;
    logic stable;
    logic rise;

    modport src (input raw_level, output stable, output rise);
    modport dst (output raw_level, input stable, input rise);
endinterface : rsf_sync_if
